//--- logic/pin_filter.sv
// three-stage pin synchroniser with per-bit stability filter
`timescale 1ns/100ps
module pin_filter #(
  parameter int WIDTH = 8,
  parameter int STABLE = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
)(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] level_o
);
  localparam int CW = $clog2(STABLE + 1);
  logic [WIDTH-1:0] s1_q, s2_q, s3_q, level_q, level_d;
  logic [CW-1:0] cnt_q [WIDTH];
  logic [CW-1:0] cnt_d [WIDTH];

  // ==========================================
  // filter
  always_comb begin
    level_d = level_q;
    for (int i = 0; i < WIDTH; i++) begin
      cnt_d[i] = '0;
      if (s2_q[i] == s3_q[i] && s3_q[i] != level_q[i]) begin
        if (cnt_q[i] == CW'(STABLE - 1)) begin
          level_d[i] = s3_q[i]; // see R12
        end else begin
          cnt_d[i] = cnt_q[i] + CW'(1);
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
      level_q <= RST_VAL;
      for (int i = 0; i < WIDTH; i++) begin
        cnt_q[i] <= '0;
      end
    end else if (clk_en_i) begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      level_q <= level_d;
      cnt_q <= cnt_d;
    end
  end

  assign level_o = level_q;

  // ==========================================
  // assertions
  for (genvar g = 0; g < WIDTH; g++) begin : g_chk
    a_filter_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      $changed(level_q[g]) |-> $past(cnt_q[g]) == CW'(STABLE - 1) && $past(s3_q[g]) == level_q[g]) // see R12
      else $error("filtered level changed before the stable count");
  end
endmodule

//--- logic/scan_matrix_panel_io.sv
// panel key matrix scanner, led matrix driver, direct i/o and station mapping
// Operation
// R1 - key scanner reads 64 keys as eight commons by eight data lines
// R2 - key data of a common captured only while that common is low
// R3 - commons step in turn, 1.46ms each, 11.68ms per full cycle
// R4 - panel holds each key at least 11.68ms and one ladder cycle
// R5 - led driver runs 64 outputs as two 4-common by 8-data matrices
// R6 - led data shown, lit only while the group common is high
// R7 - led commons rotate, each high 1.46ms once every 5.84ms
// R8 - two scan selectors each map 32 inputs and 32 outputs to a station
// R9 - direct io selector maps 32 inputs and 32 outputs to its station
// R10 - installer sets distinct station numbers 0 to 7, eight at most
// R11 - one link alarm per selector, raised when its station fails; the code raises it when its station number equals another selector's
// R12 - direct inputs report a change after 2.2ms to 11ms
// R13 - panel builder fits a sneak-path diode with every key
// R14 - key commons and data active low, pressed key reads low
// R15 - eight data bits latched at slot end into a 64-bit key image
//
// The placing of the registers and the Avalon-MM register port were decided locally.
`timescale 1ns/100ps
`include "scan_panel_cfg.svh"
module scan_matrix_panel_io #(
  parameter int SLOT_CYCLES = (`SP_SLOT_NS + `SP_CLK_NS - 1) / `SP_CLK_NS,
  parameter int DEB_CYCLES = (`SP_DEB_NS + `SP_CLK_NS - 1) / `SP_CLK_NS,
  parameter int DIO_WIDTH = 32
)(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input scan_panel_pkg::avm_req_t bus_i,
  output logic [31:0] avm_readdata_o,
  output logic avm_waitrequest_o,
  output logic [`SP_KEY_ROWS-1:0] key_row_select_n_o,
  input wire logic [`SP_KEY_COLS-1:0] key_column_sense_n_i,
  output logic [`SP_LED_COMMONS-1:0] led_group_common_a_o,
  output logic [`SP_LED_COMMONS-1:0] led_group_common_b_o,
  output logic [`SP_KEY_COLS-1:0] led_segment_line_a_o,
  output logic [`SP_KEY_COLS-1:0] led_segment_line_b_o,
  input wire logic [DIO_WIDTH-1:0] direct_in_i,
  output logic [DIO_WIDTH-1:0] direct_out_o,
  input wire logic [2:0] scan_station_sel_first_i,
  input wire logic [2:0] scan_station_sel_second_i,
  input wire logic [2:0] direct_io_station_sel_i,
  output logic first_scan_link_alarm_o,
  output logic second_scan_link_alarm_o,
  output logic direct_io_link_alarm_o,
  output logic irq_o
);
  localparam int SW = $clog2(SLOT_CYCLES + 1);
  localparam int IMG = `SP_KEY_ROWS * `SP_KEY_COLS;

  logic [SW-1:0] slot_cnt_q, slot_cnt_d;
  logic [2:0] row_q, row_d;
  logic [IMG-1:0] key_img_q, key_img_d;
  logic [IMG-1:0] led_img_q, led_img_d;
  logic [`SP_KEY_ROWS-1:0] key_row_d;
  logic [`SP_LED_COMMONS-1:0] led_common_d;
  logic [`SP_KEY_COLS-1:0] seg_a_d, seg_b_d;
  logic [`SP_KEY_COLS-1:0] key_sense_n;
  logic [DIO_WIDTH-1:0] dio_level, dio_prev_q, dio_out_d;
  logic [8:0] sel_raw;
  scan_panel_pkg::station_sel_t sel;
  scan_panel_pkg::bus_state_t bus_state_q, bus_state_d;
  logic [31:0] rdata_d, read_word, ctrl_q, ctrl_d;
  logic [`SP_EV_WIDTH-1:0] status_q, status_d, mask_q, mask_d, ev_set;
  logic [2:0] alarm_q, alarm_d;
  logic scan_en, slot_end, req, acc_wr;
  logic [2:0] st_idx;

  // ==========================================
  // pin synchronisers
  pin_filter #(.WIDTH(`SP_KEY_COLS), .STABLE(1), .RST_VAL('1)) u_key_sync (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .clk_en_i(clk_en_i),
    .pin_i(key_column_sense_n_i),
    .level_o(key_sense_n)
  );

  pin_filter #(.WIDTH(9), .STABLE(1)) u_sel_sync (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .clk_en_i(clk_en_i),
    .pin_i({scan_station_sel_first_i, scan_station_sel_second_i, direct_io_station_sel_i}),
    .level_o(sel_raw)
  );

  pin_filter #(.WIDTH(DIO_WIDTH), .STABLE(DEB_CYCLES)) u_dio_filter (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .clk_en_i(clk_en_i),
    .pin_i(direct_in_i),
    .level_o(dio_level) // see R12
  );

  assign sel = scan_panel_pkg::station_sel_t'(sel_raw);

  // ==========================================
  // key and led scan
  assign scan_en = ctrl_q[0];
  assign slot_end = slot_cnt_q == SW'(SLOT_CYCLES - 1);

  always_comb begin
    slot_cnt_d = slot_cnt_q;
    row_d = row_q;
    key_img_d = key_img_q;
    if (!scan_en) begin
      slot_cnt_d = '0;
      row_d = '0;
    end else if (slot_end) begin
      slot_cnt_d = '0;
      row_d = row_q + 3'h1; // see R3
      key_img_d[{row_q, 3'h0} +: `SP_KEY_COLS] = ~key_sense_n; // see R2, R14, R15
    end else begin
      slot_cnt_d = slot_cnt_q + SW'(1);
    end
    key_row_d = scan_en ? ~(8'h01 << row_d) : 8'hFF; // see R1, R14
    led_common_d = scan_en ? 4'h1 << row_d[1:0] : 4'h0; // see R5, R7
    seg_a_d = led_img_q[{1'b0, row_d[1:0], 3'h0} +: `SP_KEY_COLS]; // see R6
    seg_b_d = led_img_q[{1'b1, row_d[1:0], 3'h0} +: `SP_KEY_COLS]; // see R6
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      slot_cnt_q <= '0;
      row_q <= '0;
      key_img_q <= '0;
      key_row_select_n_o <= 8'hFF;
      led_group_common_a_o <= 4'h0;
      led_group_common_b_o <= 4'h0;
      led_segment_line_a_o <= 8'h00;
      led_segment_line_b_o <= 8'h00;
    end else if (clk_en_i) begin
      slot_cnt_q <= slot_cnt_d;
      row_q <= row_d;
      key_img_q <= key_img_d;
      key_row_select_n_o <= key_row_d;
      led_group_common_a_o <= led_common_d;
      led_group_common_b_o <= led_common_d;
      led_segment_line_a_o <= seg_a_d;
      led_segment_line_b_o <= seg_b_d;
    end
  end

  // ==========================================
  // station read decode
  assign st_idx = bus_i.address[4:2];

  always_comb begin
    read_word = '0;
    if (bus_i.address < `SP_OFF_STATUS) begin
      if (st_idx == sel.first) begin
        read_word = key_img_q[31:0]; // see R8
      end else if (st_idx == sel.second) begin
        read_word = key_img_q[63:32]; // see R8
      end else if (st_idx == sel.direct_io_station_sel) begin
        read_word = dio_level; // see R9
      end
    end else if (bus_i.address == `SP_OFF_STATUS) begin
      read_word = 32'(status_q);
    end else if (bus_i.address == `SP_OFF_MASK) begin
      read_word = 32'(mask_q);
    end else if (bus_i.address == `SP_OFF_CTRL) begin
      read_word = ctrl_q;
    end else if (bus_i.address == `SP_OFF_STATION) begin
      read_word = {20'h00000, alarm_q, sel_raw};
    end
  end

  // ==========================================
  // bus slave, registers and events
  assign req = bus_i.read | bus_i.write;
  assign acc_wr = bus_state_q == scan_panel_pkg::BUS_ACK && bus_i.write;

  always_comb begin
    alarm_d[2] = sel.first == sel.second || sel.first == sel.direct_io_station_sel; // see R11
    alarm_d[1] = sel.second == sel.first || sel.second == sel.direct_io_station_sel; // see R11
    alarm_d[0] = sel.direct_io_station_sel == sel.first || sel.direct_io_station_sel == sel.second; // see R11
    ev_set = '0;
    ev_set[2:0] = alarm_d & ~alarm_q;
    ev_set[`SP_EV_KEYCYC] = scan_en && slot_end && row_q == 3'h7;
    ev_set[`SP_EV_DIOCHG] = dio_level != dio_prev_q;
    bus_state_d = bus_state_q;
    rdata_d = avm_readdata_o;
    ctrl_d = ctrl_q;
    mask_d = mask_q;
    led_img_d = led_img_q;
    dio_out_d = direct_out_o;
    status_d = status_q | ev_set;
    if (bus_state_q == scan_panel_pkg::BUS_IDLE) begin
      if (req) begin
        bus_state_d = scan_panel_pkg::BUS_ACK;
        rdata_d = read_word;
      end
    end else begin
      bus_state_d = scan_panel_pkg::BUS_IDLE;
    end
    if (acc_wr) begin
      if (bus_i.address < `SP_OFF_STATUS) begin
        if (st_idx == sel.first) begin
          led_img_d[31:0] = bus_i.writedata; // see R8
        end else if (st_idx == sel.second) begin
          led_img_d[63:32] = bus_i.writedata; // see R8
        end else if (st_idx == sel.direct_io_station_sel) begin
          dio_out_d = bus_i.writedata; // see R9
        end
      end else if (bus_i.address == `SP_OFF_STATUS) begin
        status_d = (status_q & ~bus_i.writedata[`SP_EV_WIDTH-1:0]) | ev_set;
      end else if (bus_i.address == `SP_OFF_MASK) begin
        mask_d = bus_i.writedata[`SP_EV_WIDTH-1:0];
      end else if (bus_i.address == `SP_OFF_CTRL) begin
        ctrl_d = {31'h00000000, bus_i.writedata[0]};
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      bus_state_q <= scan_panel_pkg::BUS_IDLE;
      avm_readdata_o <= '0;
      ctrl_q <= `SP_CTRL_RST;
      mask_q <= '0;
      status_q <= '0;
      led_img_q <= '0;
      direct_out_o <= '0;
      alarm_q <= '0;
      dio_prev_q <= '0;
    end else if (clk_en_i) begin
      bus_state_q <= bus_state_d;
      avm_readdata_o <= rdata_d;
      ctrl_q <= ctrl_d;
      mask_q <= mask_d;
      status_q <= status_d;
      led_img_q <= led_img_d;
      direct_out_o <= dio_out_d;
      alarm_q <= alarm_d;
      dio_prev_q <= dio_level;
    end
  end

  assign avm_waitrequest_o = req && bus_state_q != scan_panel_pkg::BUS_ACK;
  assign first_scan_link_alarm_o = alarm_q[2];
  assign second_scan_link_alarm_o = alarm_q[1];
  assign direct_io_link_alarm_o = alarm_q[0];
  assign irq_o = |(status_q & mask_q);

  // ==========================================
  // assertions
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  a_row_one_low: assert property ($onehot0(~key_row_select_n_o)) // see R1
    else $error("more than one key common low");
  a_key_capture_slot: assert property ($changed(key_img_q) |-> $past(slot_end && scan_en && clk_en_i)) // see R2
    else $error("key image changed outside a slot end");
  a_row_step_slot: assert property ($changed(row_q) && $past(scan_en) |-> $past(slot_cnt_q) == SW'(SLOT_CYCLES - 1)) // see R3
    else $error("key common stepped before slot end");
  a_key_latch_low: assert property (slot_end && scan_en && clk_en_i |=>
    key_img_q[{$past(row_q), 3'h0} +: 8] == ~$past(key_sense_n)) // see R14
    else $error("key image not inverted key data");
  a_led_banks_one: assert property ($onehot0(led_group_common_a_o) && led_group_common_a_o == led_group_common_b_o) // see R5
    else $error("led commons not one-hot or banks differ");
  a_led_data_shown: assert property ($stable(led_img_q) && |led_group_common_a_o |->
    led_segment_line_a_o == led_img_q[{1'b0, row_q[1:0], 3'h0} +: 8]) // see R6
    else $error("led data does not match lit common");
  a_led_rotate: assert property ($rose(led_group_common_a_o[1]) |-> $past(led_group_common_a_o[0])) // see R7
    else $error("led commons out of order");
  a_scan_read_map: assert property (bus_state_q == scan_panel_pkg::BUS_ACK && bus_i.read && $past(clk_en_i) &&
    $stable(sel_raw) && $stable(key_img_q) && bus_i.address == {3'h0, sel.first, 2'h0} |->
    avm_readdata_o == key_img_q[31:0]) // see R8
    else $error("first scan station read wrong data");
  a_dio_write_map: assert property (acc_wr && clk_en_i && bus_i.address == {3'h0, sel.direct_io_station_sel, 2'h0} &&
    sel.direct_io_station_sel != sel.first && sel.direct_io_station_sel != sel.second |=> direct_out_o == $past(bus_i.writedata)) // see R9
    else $error("direct output write lost");
  a_alarm_dup: assert property (clk_en_i && sel.first == sel.second |=> first_scan_link_alarm_o && second_scan_link_alarm_o) // see R11
    else $error("duplicate station without alarm");

  c_key_cycle: cover property (scan_en && slot_end && row_q == 3'h7);
  c_led_rotate: cover property ($rose(led_group_common_a_o[3]));
  c_bus_write: cover property (acc_wr && clk_en_i);
  c_irq: cover property ($rose(irq_o));
endmodule

//--- logic/scan_panel_cfg.svh
// constants for the panel scan and direct i/o block
`ifndef SCAN_PANEL_CFG_SVH
`define SCAN_PANEL_CFG_SVH
`define SP_CLK_NS 4
`define SP_SLOT_NS 1460000
`define SP_DEB_NS 2200000
`define SP_KEY_ROWS 8
`define SP_KEY_COLS 8
`define SP_LED_COMMONS 4
`define SP_OFF_STATUS 8'h20
`define SP_OFF_MASK 8'h24
`define SP_OFF_CTRL 8'h28
`define SP_OFF_STATION 8'h2C
`define SP_CTRL_RST 32'h00000001
`define SP_EV_KEYCYC 3
`define SP_EV_DIOCHG 4
`define SP_EV_WIDTH 5
`endif

//--- logic/scan_panel_pkg.sv
// types shared by the panel scan and direct i/o block
package scan_panel_pkg;
  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [31:0] writedata;
  } avm_req_t;
  typedef struct packed {
    logic [2:0] first;
    logic [2:0] second;
    logic [2:0] direct_io_station_sel;
  } station_sel_t;
  typedef enum logic {BUS_IDLE, BUS_ACK} bus_state_t;
endpackage

//--- testbench/panel_matrix_model.sv
// key matrix of the operator panel, one blocking diode per key
`timescale 1ns/100ps
module panel_matrix_model (
  input wire logic [7:0] key_row_select_n_i,
  input wire logic [63:0] pressed_i,
  output logic [7:0] key_column_sense_n_o
);
  // ============================================================
  // matrix response
  always_comb begin
    key_column_sense_n_o = 8'hFF; // pull-ups while no row is driven
    for (int r = 0; r < 8; r++) begin
      if (key_row_select_n_i[r] === 1'b0) begin
        key_column_sense_n_o &= ~pressed_i[r*8 +: 8]; // only the driven row reaches data lines
      end
    end
  end
endmodule

//--- testbench/scan_matrix_panel_io_bench.sv
// self-checking bench for the panel scan and direct i/o block
`timescale 1ns/100ps
`include "scan_panel_cfg.svh"
module scan_matrix_panel_io_bench;
  localparam int SLOT = 8;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  scan_panel_pkg::avm_req_t bus = '0;
  logic [31:0] rdata, dio_in = '0;
  logic [7:0] rows_n, sense_n;
  logic [3:0] com_a, com_b;
  logic [7:0] seg_a, seg_b;
  logic [31:0] dio_out;
  logic [2:0] sel1 = 3'h0, sel2 = 3'h1, sel3 = 3'h2;
  logic alm1, second_scan_link_alarm, direct_io_link_alarm, irq, wreq;
  logic [63:0] pressed = '0;
  logic clk_en = 1'b1;
  logic [31:0] q_rd;
  logic [11:0] snap;
  int n_fail = 0;
  int compares = 0;
  always #2 ref_clk_i = ~ref_clk_i;
  // ============================================================
  // design and panel
  scan_matrix_panel_io #(.SLOT_CYCLES(SLOT), .DEB_CYCLES(5)) scan_matrix_panel_io_inst (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en), .bus_i(bus),
    .avm_readdata_o(rdata), .avm_waitrequest_o(wreq), .key_row_select_n_o(rows_n),
    .key_column_sense_n_i(sense_n), .led_group_common_a_o(com_a), .led_group_common_b_o(com_b),
    .led_segment_line_a_o(seg_a), .led_segment_line_b_o(seg_b), .direct_in_i(dio_in),
    .direct_out_o(dio_out), .scan_station_sel_first_i(sel1), .scan_station_sel_second_i(sel2),
    .direct_io_station_sel_i(sel3), .first_scan_link_alarm_o(alm1),
    .second_scan_link_alarm_o(second_scan_link_alarm), .direct_io_link_alarm_o(direct_io_link_alarm), .irq_o(irq));
  panel_matrix_model panel_matrix_model_inst (
    .key_row_select_n_i(rows_n), .pressed_i(pressed), .key_column_sense_n_o(sense_n));
  // ============================================================
  // checking and bus tasks
  task automatic report_and_stop;
    $display("mismatches %0d compares %0d", n_fail, compares);
    if (n_fail == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    bus <= '{read: !w, write: w, address: a, writedata: d};
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    chk(32'(n < 50), 32'h1);
    q = rdata;
    bus <= '0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask
  function automatic logic [7:0] cur(input bit led);
    return led ? {4'h0, com_a} : rows_n;
  endfunction
  // length of one common slot, next common, full rotation
  task automatic span(input bit led, input logic [7:0] v, input logic [7:0] nxt, input int per);
    int c;
    c = 0;
    while (cur(led) === v && c < 200) begin
      @(negedge ref_clk_i);
      c++;
    end
    c = 0;
    while (cur(led) !== v && c < 200) begin
      @(negedge ref_clk_i);
      c++;
    end
    c = 0;
    do begin
      @(negedge ref_clk_i);
      c++;
    end while (cur(led) === v && c < 200);
    chk(32'(c), 32'(SLOT));
    chk({24'h0, cur(led)}, {24'h0, nxt});
    do begin
      @(negedge ref_clk_i);
      c++;
    end while (cur(led) !== v && c < 200);
    chk(32'(c), 32'(per));
  endtask
  // ============================================================
  // tests
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    n_fail++;
    report_and_stop;
  end
  initial begin
    repeat (10) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    repeat (10) @(posedge ref_clk_i);
    wr(`SP_OFF_STATUS, 32'h1F);
    rd(`SP_OFF_STATION, 32'h0000000A);
    chk({29'h0, alm1, second_scan_link_alarm, direct_io_link_alarm}, 32'h0);
    rd(`SP_OFF_CTRL, 32'h1);
    wr(8'h30, 32'hFFFFFFFF);
    rd(8'h30, 32'h0);
    pressed <= 64'hA5C3_0F81_7E24_1866; // held for several full scans
    repeat (150) @(posedge ref_clk_i);
    rd(8'h00, 32'h7E241866);
    rd(8'h04, 32'hA5C30F81);
    xfer(1'b0, `SP_OFF_STATUS, 32'h0, q_rd);
    chk(q_rd & 32'h8, 32'h8);
    span(1'b0, 8'hFE, 8'hFD, 8 * SLOT);
    span(1'b0, 8'h7F, 8'hFE, 8 * SLOT);
    wr(8'h00, 32'h44332211);
    wr(8'h04, 32'h88776655);
    for (int k = 0; k < 4; k++) begin
      span(1'b1, 8'(1 << k), 8'(1 << ((k + 1) % 4)), 4 * SLOT);
      span(1'b1, 8'(1 << k), 8'(1 << ((k + 1) % 4)), 4 * SLOT);
      while (com_a !== 4'(1 << k)) @(negedge ref_clk_i);
      chk({28'h0, com_b}, 32'(1 << k));
      chk({seg_b, seg_a}, {8'(8'h55 + 8'h11 * k), 8'(8'h11 + 8'h11 * k)});
    end
    wr(8'h08, 32'hDEADBEEF);
    repeat (2) @(negedge ref_clk_i);
    chk(dio_out, 32'hDEADBEEF);
    wr(`SP_OFF_MASK, 32'h10);
    dio_in <= 32'h12345678;
    rd(8'h08, 32'h0);
    repeat (30) @(posedge ref_clk_i);
    rd(8'h08, 32'h12345678);
    repeat (2) @(negedge ref_clk_i);
    chk({31'h0, irq}, 32'h1);
    wr(`SP_OFF_STATUS, 32'h10);
    repeat (2) @(negedge ref_clk_i);
    chk({31'h0, irq}, 32'h0);
    wr(`SP_OFF_MASK, 32'h0);
    sel2 <= 3'h0;
    repeat (20) @(posedge ref_clk_i);
    chk({30'h0, alm1, second_scan_link_alarm}, 32'h3);
    chk({31'h0, direct_io_link_alarm}, 32'h0);
    xfer(1'b0, `SP_OFF_STATION, 32'h0, q_rd);
    chk({29'h0, q_rd[11:9]}, 32'h6);
    rd(8'h00, 32'h7E241866);
    sel2 <= 3'h1; // distinct station numbers again
    repeat (20) @(posedge ref_clk_i);
    chk({29'h0, alm1, second_scan_link_alarm, direct_io_link_alarm}, 32'h0);
    wr(`SP_OFF_CTRL, 32'h0);
    repeat (3) @(negedge ref_clk_i);
    chk({20'h0, rows_n, com_a}, {20'h0, 8'hFF, 4'h0});
    wr(`SP_OFF_CTRL, 32'h1);
    repeat (3) @(posedge ref_clk_i);
    clk_en <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    snap = {rows_n, com_a};
    repeat (20) @(posedge ref_clk_i);
    chk({20'h0, rows_n, com_a}, {20'h0, snap});
    clk_en <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    report_and_stop;
  end
endmodule
